/* File: hw/cir_pkg.sv */
/*
  Constants, field layouts and carrier types for the card identity and
  configuration register set (operating conditions, card identity and
  card specific data).
  Assumes a protocol engine on the same clock decodes bus commands and
  presents one request per cycle on the request carrier.
*/
// Overview of operation
// - conditions word: 32 bits, fixed voltage window
// - busy bit 31 low until power-up finishes
// - access mode bits 30:29 read binary 10
// - identity word is 128 bits, per-device unique
// - identity fields sit at their fixed positions
// - bit 0 reads one, CRC7 above it
// - revision byte: controller and firmware counts
// - only programmable data bits change, by program
// - one-time fields take one write only
// - retained fields survive hardware reset, CMD0 and power loss
// - clear-on-power fields: cleared by reset, not CMD0
// - volatile fields reset on hardware reset and CMD0, not factory reset
// - structure 3, version 4, command classes 0x8F5
// - access time 0x27, term 1, clock 0x32
// - read length 9, no partial, no DSR
// - write length 9, no partial, factor 2
// - erase sizes 0x1F, protect group by capacity
// - format and protect bits: classes, zero defaults
// - bit strings are unsigned, MSB first
// - access only through the command requests
package cir_pkg;

  //--------------------------------------------------------------
  // carrier types
  //--------------------------------------------------------------
  typedef enum logic [1:0] {
    REQ_RD_COND,
    REQ_RD_IDENT,
    REQ_RD_DATA,
    REQ_PROG_DATA
  } cir_req_kind_t;

  typedef enum logic [2:0] {
    CLS_RO,
    CLS_OTP_R,
    CLS_OTP_W,
    CLS_RET_R,
    CLS_RET_W,
    CLS_CLR_PWR,
    CLS_VOL_R,
    CLS_VOL_W
  } cir_cls_t;

  typedef struct packed {
    logic          valid;
    cir_req_kind_t kind;
    logic [127:0]  data;
  } cir_req_t;

  typedef struct packed {
    logic         valid;
    logic         err;
    logic [127:0] data;
  } cir_resp_t;

  //--------------------------------------------------------------
  // operating conditions layout
  //--------------------------------------------------------------
  localparam int         COND_BUSY_BIT   = 31;
  localparam logic [1:0] COND_MODE_SECTOR = 2'h2;
  localparam logic [8:0] COND_HIGH_RANGE = 9'h1FF;
  localparam logic [6:0] COND_MID_RANGE  = 7'h00;
  localparam logic       COND_LOW_RANGE  = 1'b1;
  localparam logic [4:0] COND_RSVD_HI    = 5'h00;
  localparam logic [6:0] COND_RSVD_LO    = 7'h00;

  //--------------------------------------------------------------
  // card identity layout
  //--------------------------------------------------------------
  localparam logic [5:0] IDENT_RSVD     = 6'h00;
  localparam logic [1:0] PACKAGE_TYPE   = 2'h1;
  localparam logic       ALWAYS_ONE     = 1'b1;

  //--------------------------------------------------------------
  // card specific data: read-only fields, 127 down to 16
  //--------------------------------------------------------------
  localparam logic [1:0]  STRUCTURE_CODE       = 2'h3;
  localparam logic [3:0]  SPEC_VERSION         = 4'h4;
  localparam logic [1:0]  DATA_RSVD_121        = 2'h0;
  localparam logic [7:0]  READ_ACCESS_TIME     = 8'h27;
  localparam logic [7:0]  CLOCKED_ACCESS_TERM  = 8'h01;
  localparam logic [7:0]  MAX_BUS_CLOCK        = 8'h32;
  localparam logic [11:0] COMMAND_CLASS_MASK   = 12'h8F5;
  localparam logic [3:0]  READ_BLOCK_LENGTH    = 4'h9;
  localparam logic        PARTIAL_READ_ALLOWED = 1'b0;
  localparam logic        WRITE_MISALIGN_ALLOWED = 1'b0;
  localparam logic        READ_MISALIGN_ALLOWED  = 1'b0;
  localparam logic        DRIVER_STAGE_PRESENT = 1'b0;
  localparam logic [1:0]  DATA_RSVD_75         = 2'h0;
  localparam logic [11:0] DEVICE_SIZE          = 12'hFFF;
  localparam logic [2:0]  CURRENT_CODE         = 3'h7;
  localparam logic [2:0]  CAPACITY_MULTIPLIER  = 3'h7;
  localparam logic [4:0]  ERASE_GROUP_SIZE     = 5'h1F;
  localparam logic [4:0]  ERASE_GROUP_MULTIPLIER = 5'h1F;
  localparam logic [4:0]  PROTECT_GROUP_SMALL  = 5'h07;
  localparam logic [4:0]  PROTECT_GROUP_LARGE  = 5'h0F;
  localparam logic        PROTECT_GROUP_ENABLE = 1'b1;
  localparam logic [1:0]  DEFAULT_ECC          = 2'h0;
  localparam logic [2:0]  WRITE_SPEED_FACTOR   = 3'h2;
  localparam logic [3:0]  WRITE_BLOCK_LENGTH   = 4'h9;
  localparam logic        PARTIAL_WRITE_ALLOWED = 1'b0;
  localparam logic [3:0]  DATA_RSVD_20         = 4'h0;
  localparam logic        CONTENT_PROTECT_APP  = 1'b0;

  //--------------------------------------------------------------
  // programmable bits 15:8, element 0 is bit 8
  //--------------------------------------------------------------
  localparam int         PROG_LSB   = 8;
  localparam int         PROG_BITS  = 8;
  localparam logic [7:0] PROG_RESET = 8'h00;
  localparam cir_cls_t   PROG_CLS [8] = '{
    CLS_RET_R,   // bit 8, error correction code
    CLS_RET_R,   // bit 9, error correction code
    CLS_OTP_R,   // bit 10, file format
    CLS_OTP_R,   // bit 11, file format
    CLS_RET_R,   // bit 12, temporary protect
    CLS_OTP_R,   // bit 13, permanent protect
    CLS_OTP_R,   // bit 14, copy flag
    CLS_OTP_R    // bit 15, format group
  };

  //--------------------------------------------------------------
  // checksum over the 120 bits above the CRC field, MSB first
  //--------------------------------------------------------------
  localparam logic [6:0] CRC7_POLY = 7'h09;

  function automatic logic [6:0] cir_crc7(input logic [119:0] d);
    logic [6:0] c;
    logic       fb;
    c = 7'h00;
    for (int i = 119; i >= 0; i--) begin
      fb = d[i] ^ c[6];
      c  = {c[5:0], 1'b0};
      if (fb) begin
        c = c ^ CRC7_POLY;
      end
    end
    return c;
  endfunction

endpackage

/* File: hw/cir_prog_cells.sv */
/*
  Storage cells for the programmable bits of the card specific data
  register, with per-bit write, per-bit synchronous clear and a
  per-bit "has been written" flag.
  Assumes the instantiating module chooses which reset the cells follow
  and computes the masks; the cells apply them without judgement.
*/
`timescale 1ns/1ns
module cir_prog_cells
  import cir_pkg::*;
(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  // control
  input  wire logic [PROG_BITS-1:0] clr_mask,
  input  wire logic [PROG_BITS-1:0] wr_mask,
  input  wire logic [PROG_BITS-1:0] wr_data,
  // state
  output logic      [PROG_BITS-1:0] bits,
  output logic      [PROG_BITS-1:0] done
);

  typedef struct packed {
    logic [PROG_BITS-1:0] bits;
    logic [PROG_BITS-1:0] done;
  } cir_cell_st_t;

  cir_cell_st_t st_reg;
  cir_cell_st_t st_next;

  //--------------------------------------------------------------
  // next state: clear beats write so a reset request is never lost
  //--------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    for (int i = 0; i < PROG_BITS; i++) begin
      if (clr_mask[i]) begin
        st_next.bits[i] = PROG_RESET[i];
        st_next.done[i] = 1'b0;
      end else if (wr_mask[i]) begin
        st_next.bits[i] = wr_data[i];
        st_next.done[i] = 1'b1;
      end
    end
  end

  // cells default to zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '{bits: 8'h00, done: 8'h00};
    end else begin
      st_reg <= st_next;
    end
  end

  assign bits = st_reg.bits;
  assign done = st_reg.done;

endmodule

/* File: hw/cir_regs.sv */
/*
  Card identity and configuration register set: the operating
  conditions word, the card identity word and the card specific data
  word with its programmable fields.
  Assumes a protocol engine on clk decodes the bus commands, issues at
  most one request per cycle and serialises the answer; power-up
  completion and the CMD0 reset arrive as same-clock levels/pulses.
*/
`timescale 1ns/1ns
module cir_regs
  import cir_pkg::*;
#(
  parameter logic        LARGE_PART   = 1'b0,
  parameter logic [7:0]  MAKER_CODE   = 8'h5A,       // arbitrary value
  parameter logic [7:0]  OEM_CODE     = 8'hA5,       // arbitrary value
  parameter logic [47:0] PRODUCT_NAME = 48'h0102_0304_0506, // arbitrary
  parameter logic [3:0]  CTRL_REV     = 4'h1,
  parameter logic [3:0]  FW_REV       = 4'h0,
  parameter logic [31:0] SERIAL_NUM   = 32'h0000_0001,
  parameter logic [7:0]  MFG_DATE     = 8'h00
)(
  // clock and resets
  input  wire logic      clk,
  input  wire logic      rst_b,
  input  wire logic      factory_rst_b,
  // device events
  input  wire logic      power_up_done,
  input  wire logic      cmd0_reset,
  // command requests
  input  wire cir_req_t  req,
  // answers
  output cir_resp_t      resp
);

  //--------------------------------------------------------------
  // fixed images
  //--------------------------------------------------------------
  localparam logic [30:0] COND_FIXED = {
    COND_MODE_SECTOR,
    COND_RSVD_HI,
    COND_HIGH_RANGE,
    COND_MID_RANGE,
    COND_LOW_RANGE,
    COND_RSVD_LO
  };

  localparam logic [7:0] PRODUCT_REVISION = {CTRL_REV, FW_REV};

  // serial and date adjacent so a host can take them together
  localparam logic [119:0] IDENT_BODY = {
    MAKER_CODE,
    IDENT_RSVD,
    PACKAGE_TYPE,
    OEM_CODE,
    PRODUCT_NAME,
    PRODUCT_REVISION,
    SERIAL_NUM,
    MFG_DATE
  };

  localparam logic [4:0] PROTECT_GROUP_SIZE =
    LARGE_PART ? PROTECT_GROUP_LARGE : PROTECT_GROUP_SMALL;

  localparam logic [111:0] DATA_FIXED = {
    STRUCTURE_CODE,
    SPEC_VERSION,
    DATA_RSVD_121,
    READ_ACCESS_TIME,
    CLOCKED_ACCESS_TERM,
    MAX_BUS_CLOCK,
    COMMAND_CLASS_MASK,
    READ_BLOCK_LENGTH,
    PARTIAL_READ_ALLOWED,
    WRITE_MISALIGN_ALLOWED,
    READ_MISALIGN_ALLOWED,
    DRIVER_STAGE_PRESENT,
    DATA_RSVD_75,
    DEVICE_SIZE,
    CURRENT_CODE,
    CURRENT_CODE,
    CURRENT_CODE,
    CURRENT_CODE,
    CAPACITY_MULTIPLIER,
    ERASE_GROUP_SIZE,
    ERASE_GROUP_MULTIPLIER,
    PROTECT_GROUP_SIZE,
    PROTECT_GROUP_ENABLE,
    DEFAULT_ECC,
    WRITE_SPEED_FACTOR,
    WRITE_BLOCK_LENGTH,
    PARTIAL_WRITE_ALLOWED,
    DATA_RSVD_20,
    CONTENT_PROTECT_APP
  };

  // identity never changes, so its checksum is a constant
  localparam logic [6:0] IDENT_CRC = cir_crc7(IDENT_BODY);

  //--------------------------------------------------------------
  // per-bit class decode of the programmable field
  //--------------------------------------------------------------
  logic [PROG_BITS-1:0] is_nv;
  logic [PROG_BITS-1:0] is_once;
  logic [PROG_BITS-1:0] is_rd;
  logic [PROG_BITS-1:0] is_vol;

  for (genvar g = 0; g < PROG_BITS; g++) begin : g_cls
    // one-time and retained cells ride the factory reset only
    assign is_nv[g]   = (PROG_CLS[g] == CLS_OTP_R) ||
                        (PROG_CLS[g] == CLS_OTP_W) ||
                        (PROG_CLS[g] == CLS_RET_R) ||
                        (PROG_CLS[g] == CLS_RET_W);
    assign is_once[g] = (PROG_CLS[g] == CLS_OTP_R) ||
                        (PROG_CLS[g] == CLS_OTP_W) ||
                        (PROG_CLS[g] == CLS_CLR_PWR);
    assign is_rd[g]   = (PROG_CLS[g] == CLS_OTP_R) ||
                        (PROG_CLS[g] == CLS_RET_R) ||
                        (PROG_CLS[g] == CLS_CLR_PWR) ||
                        (PROG_CLS[g] == CLS_VOL_R);
    assign is_vol[g]  = (PROG_CLS[g] == CLS_VOL_R) ||
                        (PROG_CLS[g] == CLS_VOL_W);
  end

  //--------------------------------------------------------------
  // programmable cells: two banks, one per reset domain
  //--------------------------------------------------------------
  logic [PROG_BITS-1:0] nv_bits;
  logic [PROG_BITS-1:0] nv_done;
  logic [PROG_BITS-1:0] pw_bits;
  logic [PROG_BITS-1:0] pw_done;
  logic [PROG_BITS-1:0] cur_bits;
  logic [PROG_BITS-1:0] cur_done;
  logic [PROG_BITS-1:0] nv_wr_mask;
  logic [PROG_BITS-1:0] pw_wr_mask;
  logic [PROG_BITS-1:0] pw_clr_mask;
  logic [PROG_BITS-1:0] new_bits;
  logic [PROG_BITS-1:0] locked;
  logic [PROG_BITS-1:0] once_conflict;
  logic                 is_prog;
  logic                 ro_mismatch;
  logic                 prog_ok;

  assign cur_bits = (nv_bits & is_nv) | (pw_bits & ~is_nv);
  assign cur_done = (nv_done & is_nv) | (pw_done & ~is_nv);
  assign new_bits = req.data[PROG_LSB +: PROG_BITS];

  // program is refused whole when a fixed bit differs
  assign is_prog     = req.valid && (req.kind == REQ_PROG_DATA);
  assign ro_mismatch = (req.data[127:16] != DATA_FIXED);
  // a used one-time cell may be rewritten only with its own value
  assign locked        = is_once & cur_done;
  assign once_conflict = locked & (new_bits ^ cur_bits);
  assign prog_ok       = is_prog && !ro_mismatch && (once_conflict == '0);

  // locked cells are skipped so their flag stays set
  assign nv_wr_mask = {PROG_BITS{prog_ok}} & is_nv & ~locked;
  assign pw_wr_mask = {PROG_BITS{prog_ok}} & ~is_nv & ~locked;
  // CMD0 clears only volatile cells; clear-on-power keep value
  assign pw_clr_mask = {PROG_BITS{cmd0_reset}} & is_vol;

  // nonvolatile bank: power loss and hardware reset leave it alone
  cir_prog_cells u_nv_cells (
    .clk      (clk),
    .rst_b    (factory_rst_b),
    .clr_mask ({PROG_BITS{1'b0}}),
    .wr_mask  (nv_wr_mask),
    .wr_data  (new_bits),
    .bits     (nv_bits),
    .done     (nv_done)
  );

  // power bank: cleared by power-on or hardware reset
  cir_prog_cells u_pw_cells (
    .clk      (clk),
    .rst_b    (rst_b),
    .clr_mask (pw_clr_mask),
    .wr_mask  (pw_wr_mask),
    .wr_data  (new_bits),
    .bits     (pw_bits),
    .done     (pw_done)
  );

  //--------------------------------------------------------------
  // read images
  //--------------------------------------------------------------
  logic [119:0] data_body;
  logic [127:0] data_word;
  logic [127:0] ident_word;

  // write-only cells read as zero
  assign data_body  = {DATA_FIXED, cur_bits & is_rd};
  // checksum tracks the cells, so a read after a program agrees
  assign data_word  = {data_body, cir_crc7(data_body), ALWAYS_ONE};
  assign ident_word = {IDENT_BODY, IDENT_CRC, ALWAYS_ONE};

  //--------------------------------------------------------------
  // block state
  //--------------------------------------------------------------
  typedef struct packed {
    logic      pup;
    cir_resp_t resp;
  } cir_st_t;

  cir_st_t st_reg;
  cir_st_t st_next;

  // answers come one cycle after the request; no other way
  always_comb begin
    st_next = st_reg;
    st_next.resp.valid = 1'b0;
    st_next.resp.err   = 1'b0;
    if (power_up_done) begin
      st_next.pup = 1'b1;
    end
    if (req.valid) begin
      st_next.resp.valid = 1'b1;
      case (req.kind)
        REQ_RD_COND: begin
          // busy bit follows the flag as it stood at request
          st_next.resp.data = {96'h0, st_reg.pup, COND_FIXED};
        end
        REQ_RD_IDENT: begin
          st_next.resp.data = ident_word;
        end
        REQ_RD_DATA: begin
          st_next.resp.data = data_word;
        end
        REQ_PROG_DATA: begin
          st_next.resp.data = 128'h0;
          st_next.resp.err  = !prog_ok;
        end
        default: begin
          st_next.resp.data = 128'h0;
          st_next.resp.err  = 1'b1;
        end
      endcase
    end
  end

  // busy bit low from reset until power-up completes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '{pup: 1'b0, resp: '{valid: 1'b0, err: 1'b0,
                                     data: 128'h0}};
    end else begin
      st_reg <= st_next;
    end
  end

  assign resp = st_reg.resp;

  //--------------------------------------------------------------
  // checks
  //--------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_cond_fixed;
    req.valid && req.kind == REQ_RD_COND
      |=> resp.valid && resp.data[30:0] == 31'h40FF_8080
          && resp.data[127:32] == 96'h0;
  endproperty
  a_cond_fixed: assert property (p_cond_fixed)
    else $error("conditions word has wrong fixed bits");

  property p_cond_busy;
    req.valid && req.kind == REQ_RD_COND && !st_reg.pup
      |=> !resp.data[COND_BUSY_BIT];
  endproperty
  a_cond_busy: assert property (p_cond_busy)
    else $error("power-up bit set before power-up completed");

  property p_pup_rise;
    power_up_done ##[1:4] (req.valid && req.kind == REQ_RD_COND)
      |=> resp.data[COND_BUSY_BIT];
  endproperty
  a_pup_rise: assert property (p_pup_rise)
    else $error("power-up bit not set after completion");

  property p_ident_tail;
    req.valid && req.kind == REQ_RD_IDENT
      |=> resp.data[0] && resp.data[7:1] == cir_crc7(resp.data[127:8])
          && resp.data[113:112] == 2'h1;
  endproperty
  a_ident_tail: assert property (p_ident_tail)
    else $error("identity word checksum or package type wrong");

  property p_data_head;
    req.valid && req.kind == REQ_RD_DATA
      |=> resp.data[127:122] == 6'h34 && resp.data[95:84] == 12'h8F5
          && resp.data[119:96] == 24'h2701_32 && resp.data[0];
  endproperty
  a_data_head: assert property (p_data_head)
    else $error("data word header fields wrong");

  property p_data_crc;
    prog_ok ##[1:4] (req.valid && req.kind == REQ_RD_DATA)
      |=> resp.data[7:1] == cir_crc7(resp.data[127:8]);
  endproperty
  a_data_crc: assert property (p_data_crc)
    else $error("data word checksum stale after program");

  property p_ro_refuse;
    is_prog && ro_mismatch |=> resp.err && $stable(cur_bits);
  endproperty
  a_ro_refuse: assert property (p_ro_refuse)
    else $error("program with changed fixed bits was not refused");

  property p_once;
    is_prog && (once_conflict != '0)
      |=> resp.err && ((cur_bits ^ $past(cur_bits)) & is_once) == '0;
  endproperty
  a_once: assert property (p_once)
    else $error("one-time cell accepted a second value");

  property p_cmd0_clear;
    cmd0_reset |=> (cur_bits & is_vol) == '0;
  endproperty
  a_cmd0_clear: assert property (p_cmd0_clear)
    else $error("volatile cell survived CMD0");

  property p_cmd0_keep;
    cmd0_reset && !prog_ok |=> $stable(cur_bits & ~is_vol);
  endproperty
  a_cmd0_keep: assert property (p_cmd0_keep)
    else $error("retained cell changed on CMD0");

  property p_prog_take;
    prog_ok |=> ((cur_bits ^ $past(new_bits)) & is_nv & ~$past(locked))
                == '0 && resp.valid && !resp.err;
  endproperty
  a_prog_take: assert property (p_prog_take)
    else $error("accepted program did not store the new bits");

endmodule

/* File: tb/cir_host_model.sv */
/*
  Host side of the register set: issues one command request at a time
  and collects the answer that follows it.
  Assumes the register set takes a request at the edge where valid is
  high and answers at the next edge.
*/
`timescale 1ns/1ns
module cir_host_model
  import cir_pkg::*;
(
  // clock
  input  wire logic      clk,
  // request and answer
  output cir_req_t       req,
  input  wire cir_resp_t resp
);
  //--------------------------------------------------------------
  // command transfers
  //--------------------------------------------------------------
  // idle until the first command
  initial begin
    req = '0;
  end

  // registers are reached only by command requests, words MSB first
  task automatic xfer(input cir_req_kind_t kind, input logic [127:0] d,
                      output cir_resp_t r);
    @(posedge clk);
    req <= '{valid: 1'b1, kind: kind, data: d};
    @(posedge clk);
    req <= '0;
    // answer stands one cycle only: take it at the edge that ends it,
    // before that edge's update lands
    @(posedge clk);
    r = resp;
  endtask

  // unique id: serial joined with date, not the serial alone
  function automatic logic [39:0] uid(input logic [127:0] id);
    return {id[47:16], id[15:8]};
  endfunction
endmodule

/* File: tb/cir_regs_tb_top.sv */
/*
  Self-checking bench: reads the three words, programs the data word
  at random and across both reset kinds.
  Assumes the host model drives every request.
*/
`timescale 1ns/1ns
module cir_regs_tb_top
  import cir_pkg::*;
;
  `define CHK(what, exp, got) \
    begin \
      samples_checked++; \
      if ((got) !== (exp)) begin \
        n_fail++; \
        $display("BAD %s exp %h got %h", what, exp, got); \
      end \
    end
  //--------------------------------------------------------------
  // expected images
  //--------------------------------------------------------------
  localparam logic [31:0]  SERIAL = 32'hC0DE_0042;
  localparam logic [7:0]   DATE   = 8'h6B;
  localparam logic [7:0]   OTP    = 8'hEC;
  localparam logic [7:0]   MAKER  = 8'h3C;               // arbitrary value
  localparam logic [7:0]   OEM    = 8'hC3;               // arbitrary value
  localparam logic [47:0]  PNAME  = 48'h1122_3344_5566;  // arbitrary value
  localparam logic [3:0]   CREV   = 4'h2;
  localparam logic [3:0]   FREV   = 4'h5;
  // revision byte: controller count above firmware count
  localparam logic [119:0] ID_BODY = {MAKER, 6'h00, 2'h1, OEM,
    PNAME, CREV, FREV, SERIAL, DATE};
  localparam logic [111:0] IMG = {2'h3, 4'h4, 2'h0, 8'h27, 8'h01, 8'h32,
    12'h8F5, 4'h9, 4'h0, 2'h0, 12'hFFF, 15'h7FFF, 5'h1F, 5'h1F, 5'h0F,
    1'h1, 2'h0, 3'h2, 4'h9, 1'h0, 4'h0, 1'h0};
  logic         clk = 1'b0;
  logic         rst_b;
  logic         factory_rst_b;
  logic         power_up_done;
  logic         cmd0_reset;
  cir_req_t     req;
  cir_resp_t    resp;
  cir_resp_t    r;
  int           n_fail = 0;
  int           samples_checked = 0;
  int           cycles = 0;
  logic [31:0]  seed = 32'd41;
  logic [7:0]   bits = 8'h00;
  logic [7:0]   used = 8'h00;
  logic [7:0]   nb;
  logic [127:0] w;
  logic         bad;
  logic         corrupt;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // own checksum, kept apart from the design's
  function automatic logic [127:0] seal(input logic [119:0] d);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 119; i >= 0; i--) begin
      c = {c[5:0], 1'b0} ^ ((d[i] ^ c[6]) ? 7'h09 : 7'h00);
    end
    return {d, c, 1'b1};
  endfunction

  function automatic logic [127:0] cond(input logic busy);
    return {96'h0, busy, 2'h2, 5'h00, 9'h1FF, 7'h00, 1'b1, 7'h00};
  endfunction

  //--------------------------------------------------------------
  // design and host
  //--------------------------------------------------------------
  cir_regs #(
    .LARGE_PART   (1'b1),
    .MAKER_CODE   (MAKER),
    .OEM_CODE     (OEM),
    .PRODUCT_NAME (PNAME),
    .CTRL_REV     (CREV),
    .FW_REV       (FREV),
    .SERIAL_NUM   (SERIAL),
    .MFG_DATE     (DATE)
  ) u_dut (
    .clk           (clk),
    .rst_b         (rst_b),
    .factory_rst_b (factory_rst_b),
    .power_up_done (power_up_done),
    .cmd0_reset    (cmd0_reset),
    .req           (req),
    .resp          (resp)
  );

  cir_host_model u_host (
    .clk  (clk),
    .req  (req),
    .resp (resp)
  );

  always #5 clk = ~clk;

  // hang guard, a few hundred cycles are expected
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  //--------------------------------------------------------------
  // scenarios
  //--------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    factory_rst_b = 1'b0;
    power_up_done = 1'b0;
    cmd0_reset = 1'b0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    factory_rst_b <= 1'b1;
    // power-up still running: busy bit must stay low
    u_host.xfer(REQ_RD_COND, '0, r);
    `CHK("cond valid", 1'b1, r.valid)
    `CHK("cond early", cond(1'b0), r.data)
    @(posedge clk);
    power_up_done <= 1'b1;
    @(posedge clk);
    power_up_done <= 1'b0;
    u_host.xfer(REQ_RD_COND, '0, r);
    `CHK("cond ready", cond(1'b1), r.data)
    $display("test conditions done");
    u_host.xfer(REQ_RD_IDENT, '0, r);
    `CHK("ident", seal(ID_BODY), r.data)
    `CHK("uid", {SERIAL, DATE}, u_host.uid(r.data))
    u_host.xfer(REQ_RD_DATA, '0, r);
    `CHK("data default", seal({IMG, 8'h00}), r.data)
    $display("test fixed words done");
    // random programs, some with a flipped fixed bit
    for (int k = 0; k < 30; k++) begin
      seed = xs(seed);
      nb = (k == 29) ? ~bits : seed[7:0];
      if (seed[8] && k != 29) nb = (nb & ~OTP) | (bits & OTP);
      corrupt = (seed[11:9] == 3'h0);
      w = {IMG, nb, seed[23:16]};
      if (corrupt) w[16 + int'(seed[30:24]) % 112] ^= 1'b1;
      bad = corrupt || (((nb ^ bits) & used & OTP) != 8'h00);
      u_host.xfer(REQ_PROG_DATA, w, r);
      `CHK("prog err", bad, r.err)
      if (!bad) begin
        bits = nb;
        used = OTP;
      end
      u_host.xfer(REQ_RD_DATA, '0, r);
      `CHK("data prog", seal({IMG, bits}), r.data)
    end
    $display("test program done");
    // command reset then hardware reset: programmed bits survive
    @(posedge clk);
    cmd0_reset <= 1'b1;
    @(posedge clk);
    cmd0_reset <= 1'b0;
    u_host.xfer(REQ_RD_DATA, '0, r);
    `CHK("data cmd0", seal({IMG, bits}), r.data)
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    u_host.xfer(REQ_RD_COND, '0, r);
    `CHK("cond reset", cond(1'b0), r.data)
    u_host.xfer(REQ_RD_DATA, '0, r);
    `CHK("data reset", seal({IMG, bits}), r.data)
    u_host.xfer(REQ_RD_IDENT, '0, r);
    `CHK("ident reset", seal(ID_BODY), r.data)
    $display("test resets done");
    wrap_up();
  end
endmodule
